// ==== design/cpuex_alu.v ====
// eight-bit result unit for clear, invert and decrement with null detection.
// assumes a purely combinational use inside the execution core.
`timescale 1ns/10ps
`default_nettype none
`include "cpuex_defines.vh"

module cpuex_alu (
  input wire [1:0] op_sel, // operation select
  input wire [7:0] operand, // file register value
  output reg [7:0] result, // operation result
  output wire result_null // result is all zero
);

  always @* begin
    case (op_sel)
      `CPUEX_ALU_CLEAR: result = 8'h00;
      `CPUEX_ALU_INVERT: result = ~operand;
      `CPUEX_ALU_DEC: result = operand - 8'h01;
      default: result = operand;
    endcase
  end

  // full eight bits take part, so a wrap to zero counts as null
  assign result_null = (result == 8'h00);

endmodule // cpuex_alu

`default_nettype wire

// ==== design/cpuex_core.v ====
// execution core for call, watchdog kick, clear, invert, decrement and
// decrement-skip; instructions arrive over apb, file registers sit outside.
// assumes file_rdata answers file_addr in the same cycle.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cpuex_defines.vh"

// What this block does
// - call pushes program counter plus one onto the stack top first
// - call loads its 11-bit target into program counter bits 10..0
// - call fills program counter bits 12..11 from upper latch bits 4..3
// - call takes two instruction cycles
// - watchdog kick clears the watchdog counter and its prescaler
// - watchdog kick sets both active-low timeout and power-down flags
// - file clear writes zero to the addressed file register and sets null
// - accumulator clear writes zero to the accumulator and sets null
// - destination bit 0 sends result to accumulator, 1 to file register
// - file invert yields the ones' complement and updates null
// - file decrement subtracts one and updates null
// - decrement-skip subtracts one and leaves null, timeout and power-down flags unchanged; a zero result sets the skipped status bit
// - zero decrement-skip result discards next instruction, costing two cycles
module cpuex_core (
  input wire pclk, // core clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error on unmapped address
  output wire [6:0] file_addr, // file register read address
  input wire [7:0] file_rdata, // file register read data
  output reg file_we_reg, // file register write strobe
  output reg [6:0] file_waddr_reg, // file register write address
  output reg [7:0] file_wdata_reg, // file register write data
  output reg wdt_clear_reg, // clear watchdog counter and prescaler
  input wire wdt_timeout, // watchdog expired, clears timeout flag
  input wire powerdown_event, // sleep entered, clears power-down flag
  output wire [`CPUEX_PCW-1:0] pc_out, // program counter
  output wire [`CPUEX_PCW-1:0] stack_top // return address on top of stack
);

  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_SECOND = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`CPUEX_IW-1:0] instr_reg;
  reg [`CPUEX_PCW-1:0] pc_reg;
  reg [`CPUEX_PCW-1:0] pc_next;
  reg [7:0] accum_reg;
  reg [7:0] accum_next;
  reg [4:0] pc_upper_latch_reg;
  reg null_flag_reg;
  reg null_flag_next;
  reg timeout_flag_n_reg;
  reg powerdown_flag_n_reg;
  reg timeout_flag_n_next;
  reg powerdown_flag_n_next;
  reg skipped_reg;
  reg skipped_next;
  reg second_is_call_reg;
  reg second_is_call_next;
  reg [`CPUEX_PCW-1:0] stack_mem [0:`CPUEX_STACK_DEPTH-1];
  reg [2:0] stack_ptr_reg;
  reg [`CPUEX_PCW-1:0] stack_top_next;
  reg [31:0] rdata_next;
  reg push;
  reg kick;
  reg fwrite;
  reg [1:0] alu_op;
  wire [7:0] alu_result;
  wire alu_null;
  wire busy;
  wire apb_access;
  wire apb_wr;
  wire addr_ok;
  wire [5:0] opc6;
  wire [6:0] opc7;
  wire dest_file;
  wire [`CPUEX_PCW-1:0] pc_plus1;

  assign busy = ~state_reg[0];
  assign apb_access = psel & penable;
  // registers change under execution, so every access waits for idle
  assign pready = ~busy;
  assign addr_ok = (paddr == `CPUEX_OFF_INSTR) | (paddr == `CPUEX_OFF_STATUS) |
                   (paddr == `CPUEX_OFF_ACCUM) | (paddr == `CPUEX_OFF_PC) |
                   (paddr == `CPUEX_OFF_PCLATCH) | (paddr == `CPUEX_OFF_STACKTOP);
  assign pslverr = apb_access & pready & ~addr_ok;
  assign apb_wr = apb_access & pready & pwrite & addr_ok;

  assign opc6 = instr_reg[13:8];
  assign opc7 = instr_reg[13:7];
  assign dest_file = instr_reg[`CPUEX_F_DEST];
  assign file_addr = instr_reg[`CPUEX_F_ADDR_HI:0];
  assign pc_plus1 = pc_reg + 13'h0001;
  assign pc_out = pc_reg;
  assign stack_top = stack_mem[stack_ptr_reg - 3'd1];

  cpuex_alu u_alu (
    .op_sel(alu_op),
    .operand(file_rdata),
    .result(alu_result),
    .result_null(alu_null)
  );

  // decode and next-state for one instruction cycle
  always @* begin
    state_next = state_reg;
    pc_next = pc_reg;
    accum_next = accum_reg;
    null_flag_next = null_flag_reg;
    skipped_next = skipped_reg;
    second_is_call_next = second_is_call_reg;
    push = 1'b0;
    kick = 1'b0;
    fwrite = 1'b0;
    alu_op = `CPUEX_ALU_PASS;
    case (state_reg)
      ST_IDLE: begin
        if (apb_wr && paddr == `CPUEX_OFF_INSTR) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
        pc_next = pc_plus1;
        skipped_next = 1'b0;
        if (instr_reg[13:12] == `CPUEX_OPC_CALL) begin
          push = 1'b1;
          second_is_call_next = 1'b1;
          state_next = ST_SECOND;
          pc_next = pc_reg;
        end else if (instr_reg == `CPUEX_OPC_KICK) begin
          kick = 1'b1;
        end else if (opc7 == `CPUEX_OPC_FCLR) begin
          alu_op = `CPUEX_ALU_CLEAR;
          fwrite = 1'b1;
          null_flag_next = 1'b1;
        end else if (opc7 == `CPUEX_OPC_ACLR) begin
          accum_next = 8'h00;
          null_flag_next = 1'b1;
        end else if (opc6 == `CPUEX_OPC_INV || opc6 == `CPUEX_OPC_DEC) begin
          alu_op = (opc6 == `CPUEX_OPC_INV) ? `CPUEX_ALU_INVERT : `CPUEX_ALU_DEC;
          null_flag_next = alu_null;
          if (dest_file) begin
            fwrite = 1'b1;
          end else begin
            accum_next = alu_result;
          end
        end else if (opc6 == `CPUEX_OPC_DECSKIP) begin
          alu_op = `CPUEX_ALU_DEC;
          if (dest_file) begin
            fwrite = 1'b1;
          end else begin
            accum_next = alu_result;
          end
          if (alu_null) begin
            // second cycle is the no-op standing in for the skipped word
            second_is_call_next = 1'b0;
            skipped_next = 1'b1;
            state_next = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        state_next = ST_IDLE;
        if (second_is_call_reg) begin
          pc_next = {pc_upper_latch_reg[`CPUEX_LATCH_HI:`CPUEX_LATCH_LO],
                     instr_reg[`CPUEX_F_TARGET_HI:0]};
        end else begin
          pc_next = pc_plus1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // execution state, architectural registers and software writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      instr_reg <= `CPUEX_RST_INSTR;
      pc_reg <= `CPUEX_RST_PC;
      accum_reg <= `CPUEX_RST_ACCUM;
      pc_upper_latch_reg <= `CPUEX_RST_LATCH;
      null_flag_reg <= 1'b0;
      skipped_reg <= 1'b0;
      second_is_call_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      null_flag_reg <= null_flag_next;
      skipped_reg <= skipped_next;
      second_is_call_reg <= second_is_call_next;
      pc_reg <= pc_next;
      accum_reg <= accum_next;
      if (apb_wr) begin
        case (paddr)
          `CPUEX_OFF_INSTR: instr_reg <= pwdata[`CPUEX_IW-1:0];
          `CPUEX_OFF_ACCUM: accum_reg <= pwdata[7:0];
          `CPUEX_OFF_PC: pc_reg <= pwdata[`CPUEX_PCW-1:0];
          `CPUEX_OFF_PCLATCH: pc_upper_latch_reg <= pwdata[4:0];
          default: begin
          end
        endcase
      end
    end
  end

  // flags set by the kick; a same-cycle watchdog or sleep event wins
  always @* begin
    timeout_flag_n_next = timeout_flag_n_reg;
    powerdown_flag_n_next = powerdown_flag_n_reg;
    if (wdt_timeout) begin
      timeout_flag_n_next = 1'b0;
    end else if (kick) begin
      timeout_flag_n_next = 1'b1;
    end
    if (powerdown_event) begin
      powerdown_flag_n_next = 1'b0;
    end else if (kick) begin
      powerdown_flag_n_next = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else begin
      timeout_flag_n_reg <= timeout_flag_n_next;
      powerdown_flag_n_reg <= powerdown_flag_n_next;
    end
  end

  // return stack wraps silently after eight pushes, like a hardware stack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr_reg <= 3'd0;
    end else if (push) begin
      stack_ptr_reg <= stack_ptr_reg + 3'd1;
    end
  end

  always @(posedge pclk) begin
    if (push) begin
      stack_mem[stack_ptr_reg] <= pc_plus1;
    end
  end

  // file write and watchdog clear leave one cycle after the execute cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we_reg <= 1'b0;
      file_waddr_reg <= 7'h00;
      file_wdata_reg <= 8'h00;
      wdt_clear_reg <= 1'b0;
    end else begin
      file_we_reg <= fwrite;
      wdt_clear_reg <= kick;
      if (fwrite) begin
        file_waddr_reg <= file_addr;
        file_wdata_reg <= alu_result;
      end
    end
  end

  // read word built from next values, so the flop already shows the registers
  // as they stand in the access cycle; costs no wait state
  always @* begin
    stack_top_next = push ? pc_plus1 : stack_top;
    rdata_next = 32'h0000_0000;
    case (paddr)
      `CPUEX_OFF_INSTR: rdata_next[`CPUEX_IW-1:0] = instr_reg;
      `CPUEX_OFF_STATUS: begin
        rdata_next[`CPUEX_ST_BUSY] = ~state_next[0];
        rdata_next[`CPUEX_ST_NULL] = null_flag_next;
        rdata_next[`CPUEX_ST_TIMEOUT_N] = timeout_flag_n_next;
        rdata_next[`CPUEX_ST_PWRDOWN_N] = powerdown_flag_n_next;
        rdata_next[`CPUEX_ST_SKIPPED] = skipped_next;
      end
      `CPUEX_OFF_ACCUM: rdata_next[7:0] = accum_next;
      `CPUEX_OFF_PC: rdata_next[`CPUEX_PCW-1:0] = pc_next;
      `CPUEX_OFF_PCLATCH: rdata_next[4:0] = pc_upper_latch_reg;
      `CPUEX_OFF_STACKTOP: rdata_next[`CPUEX_PCW-1:0] = stack_top_next;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // a software write lands at the same edge, but apb puts a setup cycle
  // between it and any read, so the stale word is never taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rdata_next;
    end
  end

endmodule // cpuex_core

`default_nettype wire

// ==== design/cpuex_defines.vh ====
// constants for the instruction execution subset: register map, opcode fields,
// reset values and status bit positions; included by every design file of the block.
`ifndef CPUEX_DEFINES_VH
`define CPUEX_DEFINES_VH

// apb register byte offsets
`define CPUEX_OFF_INSTR     12'h000
`define CPUEX_OFF_STATUS    12'h004
`define CPUEX_OFF_ACCUM     12'h008
`define CPUEX_OFF_PC        12'h00c
`define CPUEX_OFF_PCLATCH   12'h010
`define CPUEX_OFF_STACKTOP  12'h014

// status register bit positions
`define CPUEX_ST_BUSY       0
`define CPUEX_ST_NULL       1
`define CPUEX_ST_TIMEOUT_N  2
`define CPUEX_ST_PWRDOWN_N  3
`define CPUEX_ST_SKIPPED    4

// widths
`define CPUEX_IW            14
`define CPUEX_PCW           13
`define CPUEX_STACK_DEPTH   8

// opcode patterns of 2 to 14 bits, matched against the 14-bit instruction
`define CPUEX_OPC_CALL      2'b10
`define CPUEX_OPC_KICK      14'h0064
`define CPUEX_OPC_FCLR      7'h03
`define CPUEX_OPC_ACLR      7'h02
`define CPUEX_OPC_INV       6'h09
`define CPUEX_OPC_DEC       6'h03
`define CPUEX_OPC_DECSKIP   6'h0b

// instruction fields
`define CPUEX_F_ADDR_HI     6
`define CPUEX_F_DEST        7
`define CPUEX_F_TARGET_HI   10
`define CPUEX_LATCH_HI      4
`define CPUEX_LATCH_LO      3

// alu operation select
`define CPUEX_ALU_CLEAR     2'd0
`define CPUEX_ALU_INVERT    2'd1
`define CPUEX_ALU_DEC       2'd2
`define CPUEX_ALU_PASS      2'd3

// reset values
`define CPUEX_RST_PC        13'h0000
`define CPUEX_RST_ACCUM     8'h00
`define CPUEX_RST_LATCH     5'h00
`define CPUEX_RST_INSTR     14'h0000

`endif

// ==== verification/cpuex_checker.sv ====
// port-level checks of the execution core's instruction timing and results
// assumes instructions reach the core only as apb writes to the instruction word
`timescale 1ns/10ps
`default_nettype none
module cpuex_checker (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic [7:0] file_rdata, // file read data
  input wire logic file_we_reg, // file write strobe
  input wire logic [6:0] file_waddr_reg, // file write address
  input wire logic [7:0] file_wdata_reg, // file write data
  input wire logic wdt_clear_reg, // watchdog clear pulse
  input wire logic [12:0] pc_out, // program counter
  input wire logic [12:0] stack_top // return address
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = psel && penable && pwrite && pready && paddr == 12'h000;
  wire [13:0] op = pwdata[13:0];
  wire is_call = go && op[13:12] == 2'b10;
  wire is_skip = go && op[13:8] == 6'h0b;
  wire is_dest = go && op[7] && (op[13:8] == 6'h03 || op[13:8] == 6'h09 || op[13:8] == 6'h0b);
  sequence one_busy;
    !pready ##1 pready;
  endsequence
  sequence two_busy;
    !pready ##1 !pready ##1 pready;
  endsequence
  ret_push_a:
    assert property (is_call |-> ##2 stack_top == $past(pc_out, 2) + 13'h1)
    else $error("stack top is not the return address");
  call_target_a:
    assert property (is_call |-> ##3 pc_out[10:0] == $past(op[10:0], 3))
    else $error("call target not loaded");
  call_cycles_a:
    assert property (is_call |=> two_busy)
    else $error("call length wrong");
  single_cycle_a:
    assert property (go && !is_call && !is_skip |=> one_busy)
    else $error("single cycle op length wrong");
  skip_length_a:
    assert property (is_skip |=> !pready ##1 (pready == ($past(file_rdata) != 8'h01)))
    else $error("skip length wrong");
  kick_pulse_a:
    assert property (go && op == 14'h0064 |-> ##2 wdt_clear_reg ##1 !wdt_clear_reg)
    else $error("watchdog clear pulse missing");
  file_clear_a:
    assert property (go && op[13:7] == 7'h03 |-> ##2 file_we_reg && file_wdata_reg == 8'h00
      && file_waddr_reg == $past(op[6:0], 2))
    else $error("file clear write wrong");
  dest_file_a:
    assert property (is_dest |-> ##2 file_we_reg && file_waddr_reg == $past(op[6:0], 2))
    else $error("file destination not written");
  dest_accum_a:
    assert property (go && !op[7] && op[13:8] == 6'h03 |-> ##1 !file_we_reg [*3])
    else $error("accumulator destination wrote file");
  dec_value_a:
    assert property (go && op[13:7] == 7'h07 |-> ##2 file_wdata_reg == $past(file_rdata) - 8'h01)
    else $error("decrement result wrong");
endmodule // cpuex_checker
bind cpuex_core cpuex_checker cpuex_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .file_rdata, .file_we_reg, .file_waddr_reg, .file_wdata_reg,
  .wdt_clear_reg, .pc_out, .stack_top);
`default_nettype wire

// ==== verification/tb_cpuex_core.sv ====
// self-checking bench for the execution core: apb master and a file store
// assumes the file store answers the core's read address combinationally
`timescale 1ns/10ps
`default_nettype none
`include "cpuex_defines.vh"
module tb_cpuex_core;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic wdt_timeout = '0, powerdown_event = '0, pready, pslverr, file_we_reg, wdt_clear_reg, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [6:0] file_addr, file_waddr_reg;
  logic [7:0] file_wdata_reg, fmem [0:127];
  logic [12:0] pc_out, stack_top, epc;
  int num_errors = 0, num_checks = 0;
  wire [7:0] file_rdata = fmem[file_addr];
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (file_we_reg === 1'b1) fmem[file_waddr_reg] <= file_wdata_reg;
  cpuex_core cpuex_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .file_addr, .file_rdata, .file_we_reg, .file_waddr_reg,
    .file_wdata_reg, .wdt_clear_reg, .wdt_timeout, .powerdown_event, .pc_out, .stack_top);
  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // answer and read data taken at the rising edge that shows pready high;
  // the leading edge keeps a release and the next setup apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [13:0] op, input logic [7:0] acc, input logic [4:0] st);
    apb(1'b1, `CPUEX_OFF_INSTR, {18'h0, op});
    apb(1'b0, `CPUEX_OFF_ACCUM, '0);
    chk("accum", {24'h0, acc}, rd);
    apb(1'b0, `CPUEX_OFF_STATUS, '0);
    chk("status", {27'h0, st}, rd);
    apb(1'b0, `CPUEX_OFF_PC, '0);
    chk("pc", {19'h0, epc}, rd);
  endtask
  task automatic close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    close_out;
  end
  initial begin
    foreach (fmem[i]) fmem[i] = 8'h3c;
    fmem[7'h10] = 8'h01;
    fmem[7'h11] = 8'h5a;
    fmem[7'h12] = 8'h00;
    fmem[7'h7f] = 8'h02;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CPUEX_OFF_STATUS, '0);
    chk("status", 32'h0000000c, rd);
    apb(1'b0, 12'h018, '0);
    chk("unmapped", 32'h00000001, {31'h0, err});
    apb(1'b1, `CPUEX_OFF_PC, 32'h00000100);
    epc = 13'h0101;
    run(14'h0310, 8'h00, 5'h0e);
    chk("file", 32'h01, {24'h0, fmem[7'h10]});
    epc = 13'h0102;
    run(14'h0991, 8'h00, 5'h0c);
    chk("file", 32'ha5, {24'h0, fmem[7'h11]});
    epc = 13'h0104;
    run(14'h0b90, 8'h00, 5'h1c);
    chk("file", 32'h00, {24'h0, fmem[7'h10]});
    epc = 13'h0105;
    run(14'h0392, 8'h00, 5'h0c);
    chk("file", 32'hff, {24'h0, fmem[7'h12]});
    apb(1'b1, `CPUEX_OFF_ACCUM, 32'h00000033);
    epc = 13'h0106;
    run(14'h0155, 8'h00, 5'h0e);
    epc = 13'h0107;
    run(14'h0b7f, 8'h01, 5'h0e);
    epc = 13'h0108;
    run(14'h01ff, 8'h01, 5'h0e);
    chk("file", 32'h00, {24'h0, fmem[7'h7f]});
    epc = 13'h0109;
    run(14'h0912, 8'h00, 5'h0e);
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    powerdown_event <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    powerdown_event <= 1'b0;
    apb(1'b0, `CPUEX_OFF_STATUS, '0);
    chk("status", 32'h00000002, rd);
    epc = 13'h010a;
    run(14'h0064, 8'h00, 5'h0e);
    apb(1'b1, `CPUEX_OFF_PCLATCH, 32'h00000018);
    epc = 13'h1fff;
    run(14'h27ff, 8'h00, 5'h0e);
    apb(1'b0, `CPUEX_OFF_STACKTOP, '0);
    chk("stack", 32'h0000010b, rd);
    apb(1'b1, `CPUEX_OFF_PCLATCH, 32'h0000000f);
    epc = 13'h0800;
    run(14'h2000, 8'h00, 5'h0e);
    apb(1'b0, `CPUEX_OFF_STACKTOP, '0);
    chk("stack", 32'h00000000, rd);
    close_out;
  end
endmodule // tb_cpuex_core
`default_nettype wire
